// ### hdl/pwmsb_core.sv
// Purpose: Fan drive routing, zone binding and low-duty shutoff
// Assumes: All inputs come from logic on clk_in; register port is byte wide
// Notes: Overview of operation below
// Overview of operation
// RQ1: Each channel holds a 5-bit off level in bits 7:3; times 8 gives threshold.
// RQ2: With shutoff active, output goes fully off when filtered duty is below threshold.
// RQ3: A bypassed channel filter disables that channel's shutoff completely.
// RQ4: Filter counts as disabled when its 3-bit coefficient is 000.
// RQ5: Binding bit 0 feeds zone one to the PI loop and flags its filter change.
// RQ6: Binding bit 1 feeds zone two to the PI loop and flags its filter change.
// RQ7: With both zones bound, the PI loop sees the hotter reading.
// RQ8: Binding bit 2 drives output one from the PI result.
// RQ9: Binding bit 3 drives output two from the PI result.
// RQ10: With its PI bit clear, an output takes only its lookup-table duty.
// RQ11: Table one uses zone one when bit 4 set, else zone three.
// RQ12: Table two uses zone two when bit 5 set, else zone four.
// RQ13: Table three uses zone one when bit 6 set, else zone three.
// RQ14: Table four uses zone two when bit 7 set, else zone four.
`timescale 1ns/10ps

module pwmsb_core
  import pwmsb_pkg::*;
#(
  parameter int DUTY_W = PWMSB_DUTY_W,
  parameter int TEMP_W = PWMSB_TEMP_W
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic signed [TEMP_W-1:0] zone_one_temp_in,
  input wire logic signed [TEMP_W-1:0] zone_two_temp_in,
  input wire logic signed [TEMP_W-1:0] zone_three_temp_in,
  input wire logic signed [TEMP_W-1:0] zone_four_temp_in,
  input wire logic [DUTY_W-1:0] pi_result_in,
  input wire logic [DUTY_W-1:0] lut_one_duty_in,
  input wire logic [DUTY_W-1:0] lut_two_duty_in,
  input wire logic [DUTY_W-1:0] filt_one_duty_in,
  input wire logic [DUTY_W-1:0] filt_two_duty_in,
  output logic [DUTY_W-1:0] src_one_duty_out,
  output logic [DUTY_W-1:0] src_two_duty_out,
  output logic [DUTY_W-1:0] pwm_one_duty_out,
  output logic [DUTY_W-1:0] pwm_two_duty_out,
  output logic chan_one_shut_out,
  output logic chan_two_shut_out,
  output logic chan_one_bypass_out,
  output logic chan_two_bypass_out,
  output logic signed [TEMP_W-1:0] pi_temp_out,
  output logic pi_active_out,
  output logic pi_uses_zone_one_out,
  output logic pi_uses_zone_two_out,
  output logic signed [TEMP_W-1:0] table_one_temp_out,
  output logic signed [TEMP_W-1:0] table_two_temp_out,
  output logic signed [TEMP_W-1:0] table_three_temp_out,
  output logic signed [TEMP_W-1:0] table_four_temp_out
);

  logic [7:0] filt_cfg_r;
  logic [7:0] thr_one_r;
  logic [7:0] thr_two_r;
  logic [7:0] bind_r;

  // Register decode
  wire sel_filt = (reg_addr_in == PWMSB_FILT_ADDR);
  wire sel_thr_one = (reg_addr_in == PWMSB_THR_ONE_ADDR);
  wire sel_thr_two = (reg_addr_in == PWMSB_THR_TWO_ADDR);
  wire sel_bind = (reg_addr_in == PWMSB_BIND_ADDR);

  // Reserved bits read as zero
  wire [7:0] rd_mux = sel_filt ? filt_cfg_r :
                      sel_thr_one ? thr_one_r :
                      sel_thr_two ? thr_two_r :
                      sel_bind ? bind_r : PWMSB_UNMAPPED;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      filt_cfg_r <= PWMSB_FILT_RST;
      thr_one_r <= PWMSB_THR_RST;
      thr_two_r <= PWMSB_THR_RST;
      bind_r <= PWMSB_BIND_RST;
    end else if (reg_wr_in) begin
      if (sel_filt) begin
        filt_cfg_r <= reg_wdata_in & PWMSB_FILT_MASK;
      end
      if (sel_thr_one) begin
        thr_one_r <= reg_wdata_in & PWMSB_THR_MASK; // RQ1
      end
      if (sel_thr_two) begin
        thr_two_r <= reg_wdata_in & PWMSB_THR_MASK; // RQ1
      end
      if (sel_bind) begin
        bind_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= PWMSB_UNMAPPED;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end
  end

  // Binding fields
  wire pi_uses_zone_one = bind_r[PWMSB_BIT_PI_USES_ZONE_ONE];
  wire pi_uses_zone_two = bind_r[PWMSB_BIT_PI_USES_ZONE_TWO];
  wire table_one_zone_sel = bind_r[PWMSB_BIT_T1_Z1];
  wire table_two_zone_sel = bind_r[PWMSB_BIT_T2_Z2];
  wire table_three_zone_sel = bind_r[PWMSB_BIT_T3_Z1];
  wire table_four_zone_sel = bind_r[PWMSB_BIT_T4_Z2];

  // PI temperature source: hotter of the bound processor zones
  wire zone_one_hotter = (zone_one_temp_in >= zone_two_temp_in);
  wire signed [TEMP_W-1:0] both_hot = zone_one_hotter ? zone_one_temp_in : zone_two_temp_in; // RQ7
  wire signed [TEMP_W-1:0] pi_temp_nxt =
    (pi_uses_zone_one && pi_uses_zone_two) ? both_hot : // RQ7
    pi_uses_zone_one ? zone_one_temp_in : // RQ5
    pi_uses_zone_two ? zone_two_temp_in : // RQ6
    '0;

  // Lookup-table zone selection
  wire signed [TEMP_W-1:0] t1_nxt = table_one_zone_sel ? zone_one_temp_in : zone_three_temp_in; // RQ11
  wire signed [TEMP_W-1:0] t2_nxt = table_two_zone_sel ? zone_two_temp_in : zone_four_temp_in; // RQ12
  wire signed [TEMP_W-1:0] t3_nxt = table_three_zone_sel ? zone_one_temp_in : zone_three_temp_in; // RQ13
  wire signed [TEMP_W-1:0] t4_nxt = table_four_zone_sel ? zone_two_temp_in : zone_four_temp_in; // RQ14

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pi_temp_out <= '0;
      pi_active_out <= 1'b0;
      pi_uses_zone_one_out <= 1'b0;
      pi_uses_zone_two_out <= 1'b0;
      table_one_temp_out <= '0;
      table_two_temp_out <= '0;
      table_three_temp_out <= '0;
      table_four_temp_out <= '0;
    end else begin
      pi_temp_out <= pi_temp_nxt;
      pi_active_out <= pi_uses_zone_one | pi_uses_zone_two;
      pi_uses_zone_one_out <= pi_uses_zone_one; // RQ5
      pi_uses_zone_two_out <= pi_uses_zone_two; // RQ6
      table_one_temp_out <= t1_nxt;
      table_two_temp_out <= t2_nxt;
      table_three_temp_out <= t3_nxt;
      table_four_temp_out <= t4_nxt;
    end
  end

  // Per-channel arrays
  wire [DUTY_W-1:0] lut_duty [2];
  wire [DUTY_W-1:0] filt_duty [2];
  wire [7:0] thr_reg [2];
  wire [PWMSB_COEFF_W-1:0] coeff [2];
  wire from_pi [2];
  logic [DUTY_W-1:0] src_r [2];
  logic [DUTY_W-1:0] pwm_r [2];
  logic shut_r [2];
  logic bypass_r [2];

  assign lut_duty[0] = lut_one_duty_in;
  assign lut_duty[1] = lut_two_duty_in;
  assign filt_duty[0] = filt_one_duty_in;
  assign filt_duty[1] = filt_two_duty_in;
  assign thr_reg[0] = thr_one_r;
  assign thr_reg[1] = thr_two_r;
  assign coeff[0] = filt_cfg_r[PWMSB_COEFF_ONE_LSB +: PWMSB_COEFF_W]; // RQ4
  assign coeff[1] = filt_cfg_r[PWMSB_COEFF_TWO_LSB +: PWMSB_COEFF_W]; // RQ4
  assign from_pi[0] = bind_r[PWMSB_BIT_CH1_PI];
  assign from_pi[1] = bind_r[PWMSB_BIT_CH2_PI];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      wire [PWMSB_LEVEL_W-1:0] off_level = thr_reg[ch][PWMSB_LEVEL_LSB +: PWMSB_LEVEL_W];
      // Level times eight, zero-extended to duty width
      wire [DUTY_W-1:0] threshold =
        DUTY_W'({off_level, {PWMSB_STEP_ZEROS{1'b0}}}); // RQ1
      wire bypass = (coeff[ch] == PWMSB_COEFF_BYPASS); // RQ4
      wire shut = !bypass && (filt_duty[ch] < threshold); // RQ2 RQ3
      // Source duty toward the filter
      wire [DUTY_W-1:0] src_nxt = from_pi[ch] ? pi_result_in : lut_duty[ch]; // RQ8 RQ9 RQ10

      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          src_r[ch] <= '0;
          pwm_r[ch] <= '0;
          shut_r[ch] <= 1'b0;
          bypass_r[ch] <= 1'b1;
        end else begin
          src_r[ch] <= src_nxt;
          pwm_r[ch] <= shut ? '0 : filt_duty[ch]; // RQ2
          shut_r[ch] <= shut;
          bypass_r[ch] <= bypass;
        end
      end
    end
  endgenerate

  assign src_one_duty_out = src_r[0];
  assign src_two_duty_out = src_r[1];
  assign pwm_one_duty_out = pwm_r[0];
  assign pwm_two_duty_out = pwm_r[1];
  assign chan_one_shut_out = shut_r[0];
  assign chan_two_shut_out = shut_r[1];
  assign chan_one_bypass_out = bypass_r[0];
  assign chan_two_bypass_out = bypass_r[1];

endmodule

// ### hdl/pwmsb_pkg.sv
// Purpose: Constants for the PWM shutoff and fan binding block
// Assumes: Byte-wide register port from the serial interface engine
// Notes: Offsets are the device register addresses
package pwmsb_pkg;

  localparam int PWMSB_DUTY_W = 9;
  localparam int PWMSB_TEMP_W = 8;
  localparam int PWMSB_LEVEL_W = 5;
  localparam int PWMSB_COEFF_W = 3;

  localparam logic [7:0] PWMSB_FILT_ADDR = 8'h32;
  localparam logic [7:0] PWMSB_THR_ONE_ADDR = 8'h33;
  localparam logic [7:0] PWMSB_THR_TWO_ADDR = 8'h34;
  localparam logic [7:0] PWMSB_BIND_ADDR = 8'h35;

  localparam logic [7:0] PWMSB_FILT_RST = 8'h00;
  localparam logic [7:0] PWMSB_THR_RST = 8'h00;
  localparam logic [7:0] PWMSB_BIND_RST = 8'h30;

  localparam logic [7:0] PWMSB_THR_MASK = 8'hF8;
  localparam logic [7:0] PWMSB_FILT_MASK = 8'h77;
  localparam logic [7:0] PWMSB_UNMAPPED = 8'h00;

  localparam int PWMSB_LEVEL_LSB = 3;
  localparam int PWMSB_STEP_ZEROS = 3;
  localparam int PWMSB_COEFF_ONE_LSB = 0;
  localparam int PWMSB_COEFF_TWO_LSB = 4;
  localparam logic [2:0] PWMSB_COEFF_BYPASS = 3'h0;

  localparam int PWMSB_BIT_PI_USES_ZONE_ONE = 0;
  localparam int PWMSB_BIT_PI_USES_ZONE_TWO = 1;
  localparam int PWMSB_BIT_CH1_PI = 2;
  localparam int PWMSB_BIT_CH2_PI = 3;
  localparam int PWMSB_BIT_T1_Z1 = 4;
  localparam int PWMSB_BIT_T2_Z2 = 5;
  localparam int PWMSB_BIT_T3_Z1 = 6;
  localparam int PWMSB_BIT_T4_Z2 = 7;

endpackage

// ### tb/pwmsb_properties.sv
// Purpose: Port-level checks of shutoff and zone binding
// Assumes: Default duty and temperature widths
// Notes: Bound from the testbench top file
`timescale 1ns/10ps
module pwmsb_properties (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic signed [7:0] zone_one_temp_in,
  input wire logic signed [7:0] zone_two_temp_in,
  input wire logic [8:0] filt_one_duty_in,
  input wire logic [8:0] pwm_one_duty_out,
  input wire logic [8:0] pwm_two_duty_out,
  input wire logic chan_one_shut_out,
  input wire logic chan_two_shut_out,
  input wire logic chan_one_bypass_out,
  input wire logic chan_two_bypass_out,
  input wire logic signed [7:0] pi_temp_out,
  input wire logic pi_active_out,
  input wire logic pi_uses_zone_one_out,
  input wire logic pi_uses_zone_two_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence both_bound_s;
    pi_uses_zone_one_out && pi_uses_zone_two_out;
  endsequence
  shut_one_off_a: assert property (chan_one_shut_out |-> pwm_one_duty_out == 9'h000)
    else $error("channel one shut but duty not zero");
  shut_two_off_a: assert property (chan_two_shut_out |-> pwm_two_duty_out == 9'h000)
    else $error("channel two shut but duty not zero");
  pass_one_duty_a: assert property (!chan_one_shut_out |-> pwm_one_duty_out == $past(filt_one_duty_in))
    else $error("channel one duty not the filtered duty");
  bypass_one_open_a: assert property (chan_one_bypass_out |-> !chan_one_shut_out)
    else $error("channel one shut while bypassed");
  bypass_two_open_a: assert property (chan_two_bypass_out |-> !chan_two_shut_out)
    else $error("channel two shut while bypassed");
  pi_active_flag_a: assert property (pi_active_out == (pi_uses_zone_one_out || pi_uses_zone_two_out))
    else $error("control loop active flag wrong");
  pi_hotter_zone_a: assert property (both_bound_s |-> pi_temp_out == (($past(zone_one_temp_in) >=
    $past(zone_two_temp_in)) ? $past(zone_one_temp_in) : $past(zone_two_temp_in)))
    else $error("control loop not on hotter zone");
  pi_zone_one_a: assert property (pi_uses_zone_one_out && !pi_uses_zone_two_out |->
    pi_temp_out == $past(zone_one_temp_in))
    else $error("control loop not on zone one");
  pi_zone_two_a: assert property (!pi_uses_zone_one_out && pi_uses_zone_two_out |->
    pi_temp_out == $past(zone_two_temp_in))
    else $error("control loop not on zone two");
endmodule

// ### tb/pwmsb_fan_model.sv
// Purpose: Filter and fan stage stand-in on the far side
// Assumes: Filter settles in one cycle
// Notes: Echoes the selected duty back as filtered duty
`timescale 1ns/10ps
module pwmsb_fan_model (
  input wire logic clk_in,
  input wire logic [8:0] src_one_in,
  input wire logic [8:0] src_two_in,
  output logic [8:0] filt_one_out,
  output logic [8:0] filt_two_out
);
  always_ff @(posedge clk_in) begin
    filt_one_out <= src_one_in;
    filt_two_out <= src_two_in;
  end
endmodule

// ### tb/test_pwm_shutoff_and_fan_binding.sv
// Purpose: Register and datapath tests of the shutoff and binding block
// Assumes: Byte register port, inputs driven at falling edge
// Notes: Expected values follow the register map and binding bits
`timescale 1ns/10ps
module test_pwm_shutoff_and_fan_binding;
  import pwmsb_pkg::*;
  logic clk_in = 0, srst_in = 1, reg_wr_in = 0, reg_rd_in = 0, sh1, sh2, by1, by2, pia, u1, u2;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic signed [7:0] z1 = 8'sh0A, z2 = 8'sh14, z3 = 8'sh1E, z4 = 8'sh28, pt, t1, t2, t3, t4;
  logic [8:0] pr = 9'h155, l1 = 9'h0AA, l2 = 9'h0BB, f1, f2, s1, s2, p1, p2;
  int err_total = 0, checked = 0;
  pwmsb_core dut_u (.clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .zone_one_temp_in(z1),
    .zone_two_temp_in(z2), .zone_three_temp_in(z3), .zone_four_temp_in(z4), .pi_result_in(pr),
    .lut_one_duty_in(l1), .lut_two_duty_in(l2), .filt_one_duty_in(f1), .filt_two_duty_in(f2),
    .src_one_duty_out(s1), .src_two_duty_out(s2), .pwm_one_duty_out(p1), .pwm_two_duty_out(p2),
    .chan_one_shut_out(sh1), .chan_two_shut_out(sh2), .chan_one_bypass_out(by1), .chan_two_bypass_out(by2),
    .pi_temp_out(pt), .pi_active_out(pia), .pi_uses_zone_one_out(u1), .pi_uses_zone_two_out(u2),
    .table_one_temp_out(t1), .table_two_temp_out(t2), .table_three_temp_out(t3), .table_four_temp_out(t4));
  pwmsb_fan_model fan_u (.clk_in(clk_in), .src_one_in(s1), .src_two_in(s2), .filt_one_out(f1), .filt_two_out(f2));
  initial forever #10 clk_in = ~clk_in;
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    @(negedge clk_in);
    reg_wr_in = 0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in = a;
    reg_rd_in = 1;
    @(negedge clk_in);
    reg_rd_in = 0;
    chk({1'b0, reg_rdata_out}, {1'b0, e});
    @(negedge clk_in);
  endtask
  task automatic bind_chk(input logic [7:0] b);
    wr(PWMSB_BIND_ADDR, b);
    repeat (4) @(negedge clk_in);
    rd(PWMSB_BIND_ADDR, b);
    chk(t1, b[4] ? z1 : z3);
    chk(t2, b[5] ? z2 : z4);
    chk(t3, b[6] ? z1 : z3);
    chk(t4, b[7] ? z2 : z4);
    chk(pia, b[0] | b[1]);
    chk(u1, b[0]);
    chk(u2, b[1]);
    chk(pt, (b[0] && b[1]) ? ((z1 >= z2) ? z1 : z2) : b[0] ? z1 : b[1] ? z2 : 8'sh00);
    chk(s1, b[2] ? pr : l1);
    chk(s2, b[3] ? pr : l2);
  endtask
  task automatic shut_chk(input logic [8:0] a, input logic [8:0] b, input logic [8:0] ea, input logic [8:0] eb);
    l1 = a;
    l2 = b;
    repeat (4) @(negedge clk_in);
    chk(p1, ea);
    chk(sh1, ea == 9'h000);
    chk(p2, eb);
    chk(sh2, eb == 9'h000);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_in);
    srst_in = 0;
    chk(by1 & by2, 1'b1);
    for (int i = 0; i < 5; i++) rd(8'h32 + i[7:0], (i == 3) ? PWMSB_BIND_RST : 8'h00);
    wr(PWMSB_THR_ONE_ADDR, 8'hFF);
    rd(PWMSB_THR_ONE_ADDR, 8'hF8);
    bind_chk(8'h35);
    bind_chk(8'hCA);
    bind_chk(8'h0F);
    bind_chk(8'hF0);
    bind_chk(8'h00);
    wr(PWMSB_FILT_ADDR, 8'h11);
    wr(PWMSB_THR_ONE_ADDR, 8'h50);
    wr(PWMSB_THR_TWO_ADDR, 8'hF8);
    shut_chk(9'h04F, 9'h0F7, 9'h000, 9'h000);
    shut_chk(9'h050, 9'h0F8, 9'h050, 9'h0F8);
    wr(PWMSB_FILT_ADDR, 8'h00);
    shut_chk(9'h04F, 9'h0F7, 9'h04F, 9'h0F7);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    err_total++;
    final_report();
  end
endmodule
bind pwmsb_core pwmsb_properties chk_u (.clk_in, .srst_in, .zone_one_temp_in, .zone_two_temp_in,
  .filt_one_duty_in, .pwm_one_duty_out, .pwm_two_duty_out, .chan_one_shut_out, .chan_two_shut_out,
  .chan_one_bypass_out, .chan_two_bypass_out, .pi_temp_out, .pi_active_out, .pi_uses_zone_one_out,
  .pi_uses_zone_two_out);
